// File: verilog/pmic_pkg.sv
// shared constants and types for the power mode controller
`default_nettype none
package pmic_pkg;
	// power mode encoding
	typedef enum logic [2:0] {
		PMIC_NORMAL = 3'h0,
		PMIC_IDLE = 3'h1,
		PMIC_STOP = 3'h2,
		PMIC_SUSPEND = 3'h3,
		PMIC_SLEEP = 3'h4
	} pmic_mode_t;
	// bit positions inside power_control_reg
	localparam int unsigned PMIC_IDLE_BIT = 0;
	localparam int unsigned PMIC_STOP_BIT = 1;
	localparam logic [1:0] PMIC_POWER_CONTROL_REG_RST = 2'h0;
	// fetch address after any reset
	localparam logic [15:0] PMIC_RESET_VECTOR = 16'h0000;
endpackage
`default_nettype wire

// File: verilog/pmic_power_mode_ctrl.sv
// power mode controller: normal, idle, stop, suspend and sleep
`timescale 1ns/1ps
`default_nettype none
module pmic_power_mode_ctrl (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// cpu side
	input wire logic i_power_control_reg_wr,
	input wire logic [1:0] i_power_control_reg_wdata,
	input wire logic i_instr_done,
	input wire logic i_pmu_suspend_req,
	input wire logic i_pmu_sleep_req,
	// wake and reset sources
	input wire logic i_irq_pending,
	input wire logic i_wdt_expire,
	input wire logic i_wake_rtc,
	input wire logic i_wake_port,
	input wire logic i_wake_cmp0,
	input wire logic i_wake_rst_pin,
	input wire logic i_two_cell,
	// status and controls
	output logic [2:0] o_mode,
	output logic [1:0] o_power_control_reg,
	output logic o_cpu_halt,
	output logic o_periph_clk_en,
	output logic o_sysclk_en,
	output logic o_prec_osc_en,
	output logic o_lp_osc_en,
	output logic o_core_supply_en,
	output logic o_wdt_reset,
	output logic o_irq_service,
	output logic [15:0] o_fetch_addr
);
	pmic_pkg::pmic_mode_t mode_q, mode_d;
	logic [1:0] power_control_reg_q, power_control_reg_d;
	logic wdt_rst_q, wdt_rst_d;
	logic svc_q, svc_d;
	logic wake_any;
	// a comparator wake is only honoured with a two-cell supply in sleep
	always_comb
	begin
		wake_any = i_wake_rtc | i_wake_port | i_wake_rst_pin;
		if (mode_q == pmic_pkg::PMIC_SLEEP)
			wake_any = wake_any | (i_wake_cmp0 & i_two_cell);
		else
			wake_any = wake_any | i_wake_cmp0;
	end
	// mode sequencing; the select bit is held until the instruction retires
	always_comb
	begin
		mode_d = mode_q;
		power_control_reg_d = power_control_reg_q;
		wdt_rst_d = 1'b0;
		svc_d = 1'b0;
		unique case (mode_q)
			pmic_pkg::PMIC_NORMAL:
			begin
				if (i_power_control_reg_wr)
					power_control_reg_d = i_power_control_reg_wdata;
				if (i_instr_done && power_control_reg_q[pmic_pkg::PMIC_STOP_BIT])
					mode_d = pmic_pkg::PMIC_STOP;
				else if (i_instr_done && power_control_reg_q[pmic_pkg::PMIC_IDLE_BIT])
					mode_d = pmic_pkg::PMIC_IDLE;
				else if (i_instr_done && i_pmu_sleep_req)
					mode_d = pmic_pkg::PMIC_SLEEP;
				else if (i_instr_done && i_pmu_suspend_req)
					mode_d = pmic_pkg::PMIC_SUSPEND;
			end
			pmic_pkg::PMIC_IDLE:
			begin
				if (i_wdt_expire)
					wdt_rst_d = 1'b1;
				else if (i_irq_pending)
				begin
					power_control_reg_d[pmic_pkg::PMIC_IDLE_BIT] = 1'b0;
					svc_d = 1'b1;
					mode_d = pmic_pkg::PMIC_NORMAL;
				end
			end
			pmic_pkg::PMIC_STOP:
			begin
				// interrupts are ignored; only a reset leaves stop
				mode_d = pmic_pkg::PMIC_STOP;
			end
			pmic_pkg::PMIC_SUSPEND, pmic_pkg::PMIC_SLEEP:
			begin
				if (wake_any)
					mode_d = pmic_pkg::PMIC_NORMAL;
			end
			default:
				mode_d = pmic_pkg::PMIC_NORMAL;
		endcase
	end
	// state registers; reset forces normal mode and clears select bits
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode_q <= pmic_pkg::PMIC_NORMAL;
			power_control_reg_q <= pmic_pkg::PMIC_POWER_CONTROL_REG_RST;
			wdt_rst_q <= 1'b0;
			svc_q <= 1'b0;
		end
		else if (i_ce)
		begin
			mode_q <= mode_d;
			power_control_reg_q <= power_control_reg_d;
			wdt_rst_q <= wdt_rst_d;
			svc_q <= svc_d;
		end
	end
	// clock and supply gating; the cpu pc is frozen, not reloaded, in idle
	assign o_mode = mode_q;
	assign o_power_control_reg = power_control_reg_q;
	assign o_cpu_halt = (mode_q != pmic_pkg::PMIC_NORMAL);
	assign o_periph_clk_en = (mode_q == pmic_pkg::PMIC_NORMAL) ||
		(mode_q == pmic_pkg::PMIC_IDLE);
	assign o_sysclk_en = (mode_q != pmic_pkg::PMIC_SUSPEND) &&
		(mode_q != pmic_pkg::PMIC_SLEEP);
	assign o_prec_osc_en = (mode_q == pmic_pkg::PMIC_NORMAL) ||
		(mode_q == pmic_pkg::PMIC_IDLE);
	assign o_lp_osc_en = o_sysclk_en;
	assign o_core_supply_en = (mode_q != pmic_pkg::PMIC_SLEEP);
	assign o_wdt_reset = wdt_rst_q;
	assign o_irq_service = svc_q;
	assign o_fetch_addr = pmic_pkg::PMIC_RESET_VECTOR;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_idle_entry: assert property (mode_q == pmic_pkg::PMIC_NORMAL && i_ce && i_instr_done
		&& power_control_reg_q == 2'h1 |=> mode_q == pmic_pkg::PMIC_IDLE)
		else $error("idle not entered");
	a_idle_no_early: assert property (mode_q == pmic_pkg::PMIC_NORMAL && !i_instr_done
		|=> mode_q == pmic_pkg::PMIC_NORMAL)
		else $error("mode left before instruction done");
	a_irq_wake: assert property (mode_q == pmic_pkg::PMIC_IDLE && i_ce && i_irq_pending
		&& !i_wdt_expire |=> !power_control_reg_q[0] && svc_q && !o_cpu_halt)
		else $error("interrupt did not wake idle");
	a_wdt_reset: assert property (mode_q == pmic_pkg::PMIC_IDLE && i_ce && i_wdt_expire
		|=> o_wdt_reset)
		else $error("watchdog reset missing");
	a_stop_hold: assert property (mode_q == pmic_pkg::PMIC_STOP
		|=> mode_q == pmic_pkg::PMIC_STOP && !o_prec_osc_en)
		else $error("stop left without reset");
	a_idle_clocks: assert property (mode_q == pmic_pkg::PMIC_IDLE
		|-> o_periph_clk_en && o_cpu_halt && $stable(power_control_reg_q))
		else $error("idle clocking wrong");
	a_sleep_supply: assert property (mode_q == pmic_pkg::PMIC_SLEEP
		|-> !o_core_supply_en && !o_sysclk_en)
		else $error("sleep supply on");
	a_cmp_onecell: assert property (mode_q == pmic_pkg::PMIC_SLEEP && !i_two_cell
		&& i_wake_cmp0 && !i_wake_rtc && !i_wake_port && !i_wake_rst_pin
		|=> mode_q == pmic_pkg::PMIC_SLEEP)
		else $error("comparator woke one-cell sleep");
	a_susp_wake: assert property (mode_q == pmic_pkg::PMIC_SUSPEND && i_ce && i_wake_rtc
		|=> mode_q == pmic_pkg::PMIC_NORMAL)
		else $error("suspend wake missed");

	// clock enable low must freeze every piece of state, or idle would lose context
	a_ce_freeze: assert property (!i_ce
		|=> $stable(mode_q) && $stable(power_control_reg_q))
		else $error("state moved while clock enable low");
	a_power_control_reg_write: assert property (mode_q == pmic_pkg::PMIC_NORMAL && i_ce && i_power_control_reg_wr
		|=> power_control_reg_q == $past(i_power_control_reg_wdata))
		else $error("select bits not written");
	// in stop, suspend and sleep the core is not running, so a write is ignored
	a_wr_refused: assert property (mode_q inside {pmic_pkg::PMIC_STOP,
		pmic_pkg::PMIC_SUSPEND, pmic_pkg::PMIC_SLEEP} && i_power_control_reg_wr
		|=> $stable(power_control_reg_q))
		else $error("select bits written while halted");
	a_stop_first: assert property (mode_q == pmic_pkg::PMIC_NORMAL && i_ce && i_instr_done
		&& power_control_reg_q[pmic_pkg::PMIC_STOP_BIT] |=> mode_q == pmic_pkg::PMIC_STOP)
		else $error("stop select not honoured");
	// the service request is a single strobe, a longer one would re-enter the handler
	a_svc_pulse: assert property (svc_q && i_ce
		|=> !svc_q)
		else $error("service strobe stretched");
	a_idle_hold: assert property (mode_q == pmic_pkg::PMIC_IDLE && !i_irq_pending
		&& !i_wdt_expire |=> mode_q == pmic_pkg::PMIC_IDLE)
		else $error("idle left without a wake source");
	a_wdt_pulse: assert property (o_wdt_reset && i_ce && !i_wdt_expire
		|=> !o_wdt_reset)
		else $error("watchdog reset request stretched");
	// the port and pin wake sources must be honoured too, not only the timer
	a_susp_port: assert property (mode_q == pmic_pkg::PMIC_SUSPEND && i_ce && i_wake_port
		|=> mode_q == pmic_pkg::PMIC_NORMAL)
		else $error("port match missed in suspend");
	a_sleep_pin: assert property (mode_q == pmic_pkg::PMIC_SLEEP && i_ce && i_wake_rst_pin
		|=> mode_q == pmic_pkg::PMIC_NORMAL)
		else $error("pin wake missed in sleep");
	a_susp_clocks: assert property (mode_q == pmic_pkg::PMIC_SUSPEND
		|-> !o_sysclk_en && !o_prec_osc_en && !o_lp_osc_en)
		else $error("oscillator left on in suspend");

	// main scenarios
	c_idle_irq: cover property (mode_q == pmic_pkg::PMIC_IDLE ##1 svc_q);
	c_idle_wdt: cover property (mode_q == pmic_pkg::PMIC_IDLE ##1 o_wdt_reset);
	c_stop: cover property (mode_q == pmic_pkg::PMIC_STOP);
	c_sleep_wake: cover property (mode_q == pmic_pkg::PMIC_SLEEP ##1
		mode_q == pmic_pkg::PMIC_NORMAL);
	c_susp_wake: cover property (mode_q == pmic_pkg::PMIC_SUSPEND ##1
		mode_q == pmic_pkg::PMIC_NORMAL);
endmodule // pmic_power_mode_ctrl
`default_nettype wire

// File: dv/pmic_cpu_model.sv
// cpu core model: writes the select bits, then retires that instruction
`timescale 1ns/1ps
`default_nettype none
module pmic_cpu_model (
	// bench request
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [1:0] i_sel,
	// power_control_reg write and retire strobes
	output logic o_power_control_reg_wr = 1'b0,
	output logic [1:0] o_power_control_reg_wdata = 2'h0,
	output logic o_instr_done = 1'b0
);
	// idle data toggles so a stale value never reads as valid
	always @(negedge i_clk)
	begin
		// the program is taken to have cleared the flash one-shot bypass already
		o_power_control_reg_wr <= i_go;
		o_power_control_reg_wdata <= i_go ? i_sel : ~o_power_control_reg_wdata;
		o_instr_done <= o_power_control_reg_wr;
	end
endmodule // pmic_cpu_model
`default_nettype wire

// File: dv/test_pmic_power_mode_ctrl.sv
// bench: mode entry, wake and reset through the cpu core model
`timescale 1ns/1ps
`default_nettype none
module test_pmic_power_mode_ctrl;
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, wr, dn, halt, pclk, sclk, posc, lposc, core, wres, svc;
	logic irq = 1'b0, wdt = 1'b0, sus = 1'b0, slp = 1'b0, rtc = 1'b0, cmp = 1'b0, two = 1'b0;
	logic ce = 1'b1, prt = 1'b0, pin = 1'b0;
	logic [1:0] sel = 2'h0, wd, power_control_reg;
	logic [2:0] mode;
	logic [15:0] fa;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	// 25 MHz clock
	initial
	begin
		forever #20 clk = ~clk;
	end
	pmic_cpu_model u_pmic_cpu_model (.i_clk(clk), .i_go(go), .i_sel(sel), .o_power_control_reg_wr(wr),
		.o_power_control_reg_wdata(wd), .o_instr_done(dn));
	pmic_power_mode_ctrl u_pmic_power_mode_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_power_control_reg_wr(wr), .i_power_control_reg_wdata(wd), .i_instr_done(dn), .i_pmu_suspend_req(sus),
		.i_pmu_sleep_req(slp), .i_irq_pending(irq), .i_wdt_expire(wdt), .i_wake_rtc(rtc),
		.i_wake_port(prt), .i_wake_cmp0(cmp), .i_wake_rst_pin(pin), .i_two_cell(two),
		.o_mode(mode), .o_power_control_reg(power_control_reg), .o_cpu_halt(halt), .o_periph_clk_en(pclk),
		.o_sysclk_en(sclk), .o_prec_osc_en(posc), .o_lp_osc_en(lposc),
		.o_core_supply_en(core), .o_wdt_reset(wres), .o_irq_service(svc), .o_fetch_addr(fa));
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask
	// write then retire; the mode lands on the rising edge before the third falling edge
	task enter(input logic [1:0] s);
		go <= 1'b1;
		sel <= s;
		w(1);
		go <= 1'b0;
		w(3);
	endtask
	task rst;
		rst_n <= 1'b0;
		w(2);
		rst_n <= 1'b1;
		w(1);
		chk({power_control_reg, mode}, 16'h0);
		chk(fa, pmic_pkg::PMIC_RESET_VECTOR);
	endtask
	task t_idle;
		enter(2'h1);
		chk({halt, pclk, posc, mode}, 16'h39);
		w(2);
		chk(power_control_reg, 16'h1);
		irq <= 1'b1;
		w(1);
		irq <= 1'b0;
		chk({power_control_reg, mode, svc}, 16'h1);
		w(1);
		chk({svc, halt}, 16'h0);
		$display("idle wake done");
	endtask
	task t_wdt;
		enter(2'h1);
		wdt <= 1'b1;
		w(1);
		wdt <= 1'b0;
		chk(wres, 16'h1);
		rst();
		$display("watchdog done");
	endtask
	task t_stop;
		enter(2'h2);
		irq <= 1'b1;
		w(2);
		irq <= 1'b0;
		chk({halt, posc, mode}, 16'h12);
		rst();
		$display("stop done");
	endtask
	task t_low;
		sus <= 1'b1;
		enter(2'h0);
		sus <= 1'b0;
		chk({sclk, lposc, mode}, 16'h3);
		rtc <= 1'b1;
		w(1);
		rtc <= 1'b0;
		chk(mode, 16'h0);
		slp <= 1'b1;
		enter(2'h0);
		slp <= 1'b0;
		cmp <= 1'b1;
		w(1);
		chk({core, mode}, 16'h4);
		two <= 1'b1;
		w(1);
		cmp <= 1'b0;
		chk(mode, 16'h0);
		sus <= 1'b1;
		enter(2'h0);
		sus <= 1'b0;
		prt <= 1'b1;
		w(1);
		prt <= 1'b0;
		chk(mode, 16'h0);
		slp <= 1'b1;
		enter(2'h0);
		slp <= 1'b0;
		pin <= 1'b1;
		w(1);
		pin <= 1'b0;
		chk(mode, 16'h0);
		$display("suspend sleep done");
	endtask
	// enable low freezes idle even with an interrupt pending
	task t_ce;
		enter(2'h1);
		ce <= 1'b0;
		irq <= 1'b1;
		w(2);
		chk({mode, svc}, 16'h2);
		ce <= 1'b1;
		w(1);
		irq <= 1'b0;
		chk({power_control_reg, mode, svc}, 16'h1);
		$display("clock enable done");
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 600)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	initial
	begin
		w(16);
		rst_n <= 1'b1;
		w(1);
		t_idle();
		t_wdt();
		t_stop();
		t_low();
		t_ce();
		end_sim();
	end
endmodule // test_pmic_power_mode_ctrl
`default_nettype wire
